// [sccfg_top.sv]
/*
 * Serial peripheral port with one 16-bit control register reached over APB.
 * Holds the role, word width, clock polarity and edge, sample phase,
 * slave-select use, pin release and two cascaded clock prescalers.
 * Transmit words come from a 32-entry FIFO filled by software writes.
 * Assumes pins are resolved outside from the enables; pin inputs are async.
 */
// Notes on behaviour
// - Clock-pin disable releases clock pin in master
// - Data-out disable releases the data output pin
// - Width bit selects 16-bit or 8-bit words
// - Sample phase: end or middle of bit
// - Clock-edge bit picks data change edge
// - Polarity bit sets idle clock level
// - Role bit selects master or slave
// - Slave-select enable qualifies slave transfers
// - Secondary prescale 111 by 1, 000 by 8
// - Primary prescale 11/10/01/00 by 1/4/16/64
// - Framed mode ignores the clock-edge bit
// - Top three control bits read zero
`timescale 1ns/1ps
`default_nettype none
module sccfg_top #(
    parameter int fifo_depth = sccfg_pkg::fifo_depth
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Serial clock pin
    input  wire logic        serial_clock_pin_i,
    output logic             serial_clock_pin_o,
    output logic             serial_clock_pin_oe_n,
    // Serial data pins
    output logic             serial_data_out_pin_o,
    output logic             serial_data_out_pin_oe_n,
    input  wire logic        serial_data_in_pin,
    // Slave select, active low
    input  wire logic        slave_select_pin_n
);
    initial
    begin
        if (fifo_depth < 2)
            $error("fifo_depth must be at least 2");
    end

    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_lead = 2'b01,
        st_trail = 2'b10
    } sccfg_state_e;

    typedef struct packed {
        sccfg_pkg::sccfg_ctrl_s ctrl;
        logic        framed;
        logic        enable;
        sccfg_state_e state;
        logic [9:0]  div_cnt;
        logic [4:0]  bit_cnt;
        logic [15:0] shift_tx;
        logic [15:0] shift_rx;
        logic [15:0] rx_data;
        logic        rx_full;
        logic        sck;
        logic        mid_sample;
        logic [2:0]  sck_sync;
        logic [1:0]  sdi_sync;
        logic [1:0]  ss_sync;
    } sccfg_st_s;

    sccfg_st_s   st_r;
    sccfg_st_s   st_nxt;
    logic        fifo_valid;
    logic        fifo_pop;
    logic [15:0] fifo_data;
    logic        fifo_full;
    logic        fifo_empty;
    logic        fifo_ready;
    logic        wr_acc;
    logic        rd_acc;
    logic        tx_push;
    logic        tick;
    logic        slave_sel;
    logic        sck_rise;
    logic        sck_fall;
    logic        lead_edge;
    logic        trail_edge;
    logic        use_edge;
    logic [4:0]  word_len;

    // secondary ratio is eight minus code times primary
    function automatic logic [9:0] div_ratio(input logic [2:0] sec, input logic [1:0] pri);
        logic [9:0] s;
        logic [9:0] p;
        s = 10'(4'd8 - {1'b0, sec});
        unique case (pri)
            2'b11: p = 10'h001;
            2'b10: p = 10'h004;
            2'b01: p = 10'h010;
            2'b00: p = 10'h040;
        endcase
        return 10'(s * p);
    endfunction

    assign wr_acc  = psel && penable && pwrite;
    assign rd_acc  = psel && penable && !pwrite;
    assign tx_push = wr_acc && (paddr == sccfg_pkg::txdata_offset);
    assign pready  = 1'b1;
    assign pslverr = 1'b0;

    assign word_len = st_r.ctrl.word_width_select ? 5'd16 : 5'd8;

    // slave-select only qualifies when enabled in slave mode
    assign slave_sel = !st_r.ctrl.slave_select_enable || !st_r.ss_sync[1];

    assign tick = (st_r.div_cnt == 10'(div_ratio(st_r.ctrl.secondary_prescale,
                                                 st_r.ctrl.primary_prescale) - 10'd1));

    // Edges of the synchronised external clock, after the two-flop stage.
    assign sck_rise = st_r.sck_sync[1] && !st_r.sck_sync[2];
    assign sck_fall = !st_r.sck_sync[1] && st_r.sck_sync[2];
    // leading edge leaves the idle level
    assign lead_edge  = st_r.ctrl.clock_polarity ? sck_fall : sck_rise;
    assign trail_edge = st_r.ctrl.clock_polarity ? sck_rise : sck_fall;
    // framed mode ignores the clock-edge bit
    assign use_edge = st_r.framed ? 1'b0 : st_r.ctrl.clock_edge;

    assign fifo_pop = st_r.enable && (st_r.state == st_idle) && fifo_valid &&
                      (st_r.ctrl.master_enable || slave_sel);

    sccfg_fifo #(
        .width(sccfg_pkg::word_bits),
        .depth(fifo_depth)
    ) u_fifo (
        .pclk      (pclk),
        .presetn   (presetn),
        .in_valid  (tx_push),
        .in_ready  (fifo_ready),
        .in_data   (pwdata[15:0]),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_data),
        .full      (fifo_full),
        .empty     (fifo_empty)
    );

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.sck_sync = {st_r.sck_sync[1:0], serial_clock_pin_i};
        st_nxt.sdi_sync = {st_r.sdi_sync[0], serial_data_in_pin};
        st_nxt.ss_sync  = {st_r.ss_sync[0], slave_select_pin_n};
        if (wr_acc && paddr == sccfg_pkg::ctrl1_offset)
            st_nxt.ctrl = pwdata[12:0];
        if (wr_acc && paddr == sccfg_pkg::config2_offset)
        begin
            st_nxt.framed = pwdata[sccfg_pkg::framed_mode_enable_pos];
            st_nxt.enable = pwdata[sccfg_pkg::port_enable_pos];
        end
        if (rd_acc && paddr == sccfg_pkg::rxdata_offset)
            st_nxt.rx_full = 1'b0;
        st_nxt.div_cnt = (tick || st_r.state == st_idle) ? 10'd0 : st_r.div_cnt + 10'd1;
        unique case (st_r.state)
            st_idle:
            begin
                // clock rests at the idle level
                st_nxt.sck = st_r.ctrl.clock_polarity;
                if (fifo_pop)
                begin
                    st_nxt.shift_tx = st_r.ctrl.word_width_select ? fifo_data
                                                                  : {fifo_data[7:0], 8'h00};
                    st_nxt.bit_cnt = 5'd0;
                    st_nxt.state = st_lead;
                end
            end
            st_lead:
            begin
                // master makes the clock; slave follows pin edges
                if (st_r.ctrl.master_enable ? tick : lead_edge)
                begin
                    st_nxt.sck = !st_r.ctrl.clock_polarity;
                    // middle sampling on the leading edge
                    if (!(st_r.ctrl.master_enable && st_r.ctrl.sample_phase))
                        st_nxt.shift_rx = {st_r.shift_rx[14:0], st_r.sdi_sync[1]};
                    // with clock-edge clear or in framed mode, data changes on idle-to-active
                    if (!use_edge && st_r.bit_cnt != 5'd0)
                        st_nxt.shift_tx = {st_r.shift_tx[14:0], 1'b0};
                    st_nxt.state = st_trail;
                end
                if (!st_r.ctrl.master_enable && !slave_sel)
                    st_nxt.state = st_idle;
            end
            st_trail:
            begin
                if (st_r.ctrl.master_enable ? tick : trail_edge)
                begin
                    st_nxt.sck = st_r.ctrl.clock_polarity;
                    // end-of-bit sampling on the trailing edge
                    if (st_r.ctrl.master_enable && st_r.ctrl.sample_phase)
                        st_nxt.shift_rx = {st_r.shift_rx[14:0], st_r.sdi_sync[1]};
                    // data changes on the trailing edge
                    if (use_edge)
                        st_nxt.shift_tx = {st_r.shift_tx[14:0], 1'b0};
                    st_nxt.bit_cnt = st_r.bit_cnt + 5'd1;
                    st_nxt.state = st_lead;
                    // stop after eight or sixteen bits
                    if (st_r.bit_cnt + 5'd1 == word_len)
                    begin
                        st_nxt.state = st_idle;
                        st_nxt.rx_full = 1'b1;
                        st_nxt.rx_data = st_r.ctrl.word_width_select
                            ? {st_nxt.shift_rx}
                            : {8'h00, st_nxt.shift_rx[7:0]};
                    end
                end
                if (!st_r.ctrl.master_enable && !slave_sel)
                    st_nxt.state = st_idle;
            end
            default:
                st_nxt.state = st_idle;
        endcase
        if (!st_r.enable)
            st_nxt.state = st_idle;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    always_comb
    begin
        prdata = 32'h0000_0000;
        if (rd_acc)
        begin
            unique case (paddr)
                sccfg_pkg::ctrl1_offset:   prdata = {19'h0_0000, st_r.ctrl};
                sccfg_pkg::status_offset:  prdata = {27'h000_0000, fifo_full, fifo_empty,
                                                     st_r.rx_full, st_r.state != st_idle,
                                                     fifo_ready};
                sccfg_pkg::rxdata_offset:  prdata = {16'h0000, st_r.rx_data};
                sccfg_pkg::config2_offset: prdata = {30'h0000_0000, st_r.enable, st_r.framed};
                default:                   prdata = 32'h0000_0000;
            endcase
        end
    end

    // master drives the clock unless clock-pin disable is set
    assign serial_clock_pin_o    = st_r.sck;
    assign serial_clock_pin_oe_n = !(st_r.ctrl.master_enable && !st_r.ctrl.clock_pin_disable);
    // data-out disable releases the output pin
    assign serial_data_out_pin_o    = st_r.shift_tx[15];
    assign serial_data_out_pin_oe_n = st_r.ctrl.data_out_pin_disable ||
        (!st_r.ctrl.master_enable && !slave_sel);

    sck_release_a: assert property (@(posedge pclk) disable iff (!presetn)
        st_r.ctrl.clock_pin_disable |-> serial_clock_pin_oe_n)
        else $error("clock pin driven while disabled");

    sdo_release_a: assert property (@(posedge pclk) disable iff (!presetn)
        st_r.ctrl.data_out_pin_disable |-> serial_data_out_pin_oe_n)
        else $error("data pin driven while disabled");

    sck_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st_r.state == st_idle) |=> st_r.sck == $past(st_r.ctrl.clock_polarity))
        else $error("clock not at idle level");

    slave_noclk_a: assert property (@(posedge pclk) disable iff (!presetn)
        !st_r.ctrl.master_enable |-> serial_clock_pin_oe_n)
        else $error("slave drives clock pin");

    byte_len_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st_r.state != st_idle && !st_r.ctrl.word_width_select) |-> st_r.bit_cnt < 5'd8)
        else $error("byte transfer overran");

    top_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_acc && paddr == sccfg_pkg::ctrl1_offset) |-> prdata[31:13] == 19'h0_0000)
        else $error("unimplemented bits read nonzero");

    sequence tick_run_s;
        (st_r.state == st_lead && st_r.ctrl.master_enable && !tick) ##1 tick;
    endsequence
    div_tick_a: assert property (@(posedge pclk) disable iff (!presetn)
        tick |-> st_r.div_cnt == 10'(div_ratio(st_r.ctrl.secondary_prescale,
                                               st_r.ctrl.primary_prescale) - 10'd1))
        else $error("divider tick at wrong count");

    lead_advance_a: assert property (@(posedge pclk) disable iff (!presetn)
        tick_run_s |=> st_r.state != st_lead || !st_r.enable || $past(wr_acc))
        else $error("leading edge missed on tick");

    ss_block_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!st_r.ctrl.master_enable && st_r.ctrl.slave_select_enable && st_r.ss_sync[1])
        |-> !fifo_pop)
        else $error("slave started while deselected");
endmodule
`default_nettype wire

// [sccfg_pkg.sv]
/*
 * Package for the serial port control block: register map, field positions,
 * reset values and the bundled types for the control register and the pin set.
 * Assumes a single 20 MHz clock domain and an APB register bus.
 */
`default_nettype none
package sccfg_pkg;
    localparam logic [11:0] ctrl1_offset    = 12'h000;
    localparam logic [11:0] status_offset   = 12'h004;
    localparam logic [11:0] txdata_offset   = 12'h008;
    localparam logic [11:0] rxdata_offset   = 12'h00C;
    localparam logic [11:0] config2_offset  = 12'h010;

    localparam int ctrl1_width            = 16;
    localparam logic [15:0] ctrl1_reset   = 16'h0000;
    localparam logic [15:0] ctrl1_mask    = 16'h1FFF;
    localparam int clock_pin_disable_pos  = 12;
    localparam int data_out_pin_disable_pos = 11;
    localparam int word_width_select_pos  = 10;
    localparam int sample_phase_pos       = 9;
    localparam int clock_edge_pos         = 8;
    localparam int slave_select_enable_pos = 7;
    localparam int clock_polarity_pos     = 6;
    localparam int master_enable_pos      = 5;
    localparam int secondary_prescale_lsb = 2;
    localparam int primary_prescale_lsb   = 0;
    localparam int framed_mode_enable_pos = 0;
    localparam int port_enable_pos        = 1;

    localparam int fifo_depth = 32;
    localparam int word_bits  = 16;

    typedef struct packed {
        logic        clock_pin_disable;
        logic        data_out_pin_disable;
        logic        word_width_select;
        logic        sample_phase;
        logic        clock_edge;
        logic        slave_select_enable;
        logic        clock_polarity;
        logic        master_enable;
        logic [2:0]  secondary_prescale;
        logic [1:0]  primary_prescale;
    } sccfg_ctrl_s;

    typedef struct packed {
        logic        sck_o;
        logic        sck_oe_n;
        logic        sdo_o;
        logic        sdo_oe_n;
    } sccfg_pins_s;
endpackage
`default_nettype wire

// [sccfg_fifo.sv]
/*
 * Synchronous flip-flop FIFO with valid/ready on both sides.
 * Assumes one clock and asynchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none
module sccfg_fifo #(
    parameter int width = 16,
    parameter int depth = 32
) (
    // Clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [width-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [width-1:0]      out_data,
    // Status
    output logic                  full,
    output logic                  empty
);
    localparam int aw = $clog2(depth);

    initial
    begin
        if (depth < 2 || (1 << aw) != depth)
            $error("fifo depth must be a power of two of at least 2");
    end

    typedef struct packed {
        logic [depth-1:0][width-1:0] mem;
        logic [aw:0]                 wr;
        logic [aw:0]                 rd;
    } sccfg_fifo_s;

    sccfg_fifo_s st_r;
    sccfg_fifo_s st_nxt;
    logic        push;
    logic        pop;

    assign empty     = (st_r.wr == st_r.rd);
    assign full      = (st_r.wr[aw-1:0] == st_r.rd[aw-1:0]) && (st_r.wr[aw] != st_r.rd[aw]);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = st_r.mem[st_r.rd[aw-1:0]];
    assign push      = in_valid && !full;
    assign pop       = out_ready && !empty;

    always_comb
    begin
        st_nxt = st_r;
        if (push)
        begin
            st_nxt.mem[st_r.wr[aw-1:0]] = in_data;
            st_nxt.wr = st_r.wr + 1'b1;
        end
        if (pop)
            st_nxt.rd = st_r.rd + 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    fifo_bound_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st_r.wr - st_r.rd) <= (aw+1)'(depth))
        else $error("fifo occupancy exceeds depth");
endmodule
`default_nettype wire

// [sccfg_slave_model.sv]
/*
 * Behavioural serial peripheral standing on the far side of the port.
 * Assumes the bench passes the clock polarity and change edge in use,
 * and pulses clear before each word it wants observed.
 */
`timescale 1ns/1ps
`default_nettype none
module sccfg_slave_model (
    // Serial lines
    input  wire logic       sck,
    input  wire logic       mosi,
    output logic            miso,
    // Bench control
    input  wire logic       cpol,
    input  wire logic       cke,
    input  wire logic       miso_level,
    input  wire logic       clear,
    // Observations
    output var logic [15:0] word,
    output var int          edges,
    output var realtime     min_gap,
    output var realtime     max_gap
);
    realtime last_t;

    // The answer line is held steady over a word, so capture timing cannot mask it.
    assign miso = miso_level;

    always @(sck or posedge clear)
    begin
        if (clear)
        begin
            word = 16'h0000;
            edges = 0;
            min_gap = 1.0e9;
            max_gap = 0.0;
        end
        else
        begin
            if (edges > 0)
            begin
                if ($realtime - last_t < min_gap)
                    min_gap = $realtime - last_t;
                if ($realtime - last_t > max_gap)
                    max_gap = $realtime - last_t;
            end
            last_t = $realtime;
            edges = edges + 1;
            if ((sck != cpol) == cke)
                word = {word[14:0], mosi};
        end
    end
endmodule
`default_nettype wire

// [spi_control_config_bench.sv]
/*
 * Self-checking bench for the serial port control block.
 * Assumes zero-wait APB, the register offsets of the package and a
 * pull-down on the clock wire and a pull-up on the data-out wire.
 */
`timescale 1ns/1ps
`default_nettype none
module spi_control_config_bench;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        sck_o;
    logic        sck_oe_n;
    logic        sdo_o;
    logic        sdo_oe_n;
    logic        ss_n;
    logic        miso;
    logic        cpol;
    logic        cke;
    logic        miso_lv;
    logic        clr;
    logic [15:0] pword;
    int          pedges;
    realtime     gmin;
    realtime     gmax;
    wire         sck_w = !sck_oe_n ? sck_o : 1'b0;
    wire         sdo_w = !sdo_oe_n ? sdo_o : 1'b1;
    int          bad_count = 0;
    int          checks = 0;
    int          cycles = 0;
    logic [31:0] rd;
    logic [31:0] m;
    logic [15:0] c;
    int          bits;
    int          r;
    localparam logic [15:0] tab [0:6] = '{16'h003B, 16'h057E, 16'h0223, 16'h003D,
                                          16'h003C, 16'h0037, 16'h013B};
    localparam logic [15:0] rel [0:5] = '{16'h0080, 16'h0080, 16'h1820, 16'h1020,
                                          16'h0820, 16'h0020};
    // Each entry: slave select level, then the two expected enables.
    localparam logic [2:0]  rel_exp [0:5] = '{3'b111, 3'b010, 3'b111, 3'b110, 3'b101, 3'b100};

    sccfg_top #(.fifo_depth(32)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .serial_clock_pin_i(sck_w),
        .serial_clock_pin_o(sck_o), .serial_clock_pin_oe_n(sck_oe_n),
        .serial_data_out_pin_o(sdo_o), .serial_data_out_pin_oe_n(sdo_oe_n),
        .serial_data_in_pin(miso), .slave_select_pin_n(ss_n));

    sccfg_slave_model partner (
        .sck(sck_w), .mosi(sdo_w), .miso(miso), .cpol(cpol), .cke(cke),
        .miso_level(miso_lv), .clear(clr), .word(pword), .edges(pedges),
        .min_gap(gmin), .max_gap(gmax));

    initial
    begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    task automatic summarize;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks = checks + 1;
        if (got !== exp)
        begin
            bad_count = bad_count + 1;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Polls status until the queue is empty, the shifter idle and n clock edges seen.
    task automatic wait_idle(input int n);
        for (int k = 0; k < 4000; k++)
        begin
            apb(1'b0, 12'h004, 32'h0000_0000, rd);
            if (rd[3] === 1'b1 && rd[1] === 1'b0 && pedges >= n)
                break;
        end
    endtask

    function automatic int ratio_of(input logic [15:0] v);
        int p;
        case (v[1:0])
            2'b11: p = 1;
            2'b10: p = 4;
            2'b01: p = 16;
            default: p = 64;
        endcase
        return (8 - int'(v[4:2])) * p;
    endfunction

    always @(posedge pclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 30000)
        begin
            bad_count = bad_count + 1;
            summarize();
        end
    end

    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        ss_n = 1'b1;
        cpol = 1'b0;
        cke = 1'b0;
        miso_lv = 1'b0;
        clr = 1'b1;
        repeat (4) @(posedge pclk);
        // Out of reset the port is a slave with select use off, so it owns the data pin.
        chk({30'b0, sck_oe_n, sdo_oe_n}, 32'h0000_0002);
        presetn <= 1'b1;
        apb(1'b0, 12'h000, 32'h0000_0000, rd);
        chk(rd, 32'h0000_0000);
        apb(1'b0, 12'h004, 32'h0000_0000, rd);
        chk(rd, 32'h0000_0009);
        apb(1'b1, 12'h000, 32'hFFFF_FFFF, rd);
        apb(1'b0, 12'h000, 32'h0000_0000, rd);
        chk(rd, 32'h0000_1FFF);
        apb(1'b1, 12'h020, 32'hFFFF_FFFF, rd);
        apb(1'b0, 12'h020, 32'h0000_0000, rd);
        chk(rd, 32'h0000_0000);
        chk({31'b0, pslverr}, 32'h0000_0000);
        chk({31'b0, pready}, 32'h0000_0001);
        // One word more than the queue holds; the last is refused.
        for (int i = 0; i < 33; i++)
            apb(1'b1, 12'h008, 32'(i), rd);
        apb(1'b0, 12'h004, 32'h0000_0000, rd);
        chk(rd & 32'h0000_0019, 32'h0000_0010);
        apb(1'b1, 12'h000, 32'h0000_003B, rd);
        apb(1'b1, 12'h010, 32'h0000_0002, rd);
        wait_idle(0);
        chk(rd & 32'h0000_001B, 32'h0000_0009);
        // Slave rows keep sample phase clear, as software must.
        for (int i = 0; i < 6; i++)
        begin
            ss_n <= rel_exp[i][2];
            apb(1'b1, 12'h000, {16'h0000, rel[i]}, rd);
            repeat (4) @(posedge pclk);
            chk({30'b0, sck_oe_n, sdo_oe_n}, 32'(rel_exp[i][1:0]));
        end
        // No row sets both prescalers to 1:1; the framed row keeps select use off.
        for (int i = 0; i < 7; i++)
        begin
            c = tab[i];
            bits = c[10] ? 16 : 8;
            r = ratio_of(c);
            m = c[10] ? 32'h0000_FFFF : 32'h0000_00FF;
            cpol <= c[6];
            cke <= (i == 6) ? 1'b0 : c[8];
            miso_lv <= i[0];
            clr <= 1'b1;
            apb(1'b1, 12'h000, {16'h0000, c}, rd);
            apb(1'b1, 12'h010, (i == 6) ? 32'h0000_0003 : 32'h0000_0002, rd);
            repeat (3) @(posedge pclk);
            chk({31'b0, sck_w}, 32'(c[6]));
            clr <= 1'b0;
            apb(1'b1, 12'h008, 32'(16'hC3A5 >> i), rd);
            wait_idle(2 * bits);
            chk(32'(pedges), 32'(2 * bits));
            chk(32'(pword) & m, 32'(16'hC3A5 >> i) & m);
            chk(32'(int'(gmin)), 32'(r * 50));
            chk(32'(int'(gmax)), 32'(r * 50));
            apb(1'b0, 12'h00C, 32'h0000_0000, rd);
            chk(rd & m, i[0] ? m : 32'h0000_0000);
            chk({31'b0, sck_w}, 32'(c[6]));
        end
        summarize();
    end
endmodule
`default_nettype wire
